//--- core/uart_regsel_pkg.sv
// shared constants and types for the uart register select block
package uart_regsel_pkg;

  // register addresses on the three select inputs
  localparam logic [2:0] ADDR_RX_TX      = 3'h0;
  localparam logic [2:0] ADDR_INT_EN     = 3'h1;
  localparam logic [2:0] ADDR_INT_ID     = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL  = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT  = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH    = 3'h7;

  // qualifier bit positions and key values
  localparam int         LC_DIV_ACCESS_BIT  = 7;
  localparam logic [7:0] LC_ENH_KEY         = 8'hBF;
  localparam int         EF_ENH_FUNC_BIT    = 4;
  localparam int         MC_PRESCALE_BIT    = 7;
  localparam int         MC_TC_TL_EN_BIT    = 6;
  localparam int         MC_LOOPBACK_BIT    = 4;
  localparam int         MC_FIFO_RDY_EN_BIT = 2;

  // values after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_PRE  = 2'h0;
  localparam logic [15:0] RESET_DIV = 16'h0000;

  // divide-by-4 prescaler wraps after this count
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // divisors the host programs for common rates
  localparam logic [15:0] DIV_1M8432_9600 = 16'h000C;
  localparam logic [15:0] DIV_1M8432_1200 = 16'h0060;
  localparam logic [15:0] DIV_1M8432_50   = 16'h0900;
  localparam logic [15:0] DIV_3M072_9600  = 16'h0014;
  localparam logic [15:0] DIV_3M072_38400 = 16'h0005;
  localparam logic [15:0] DIV_3M072_150   = 16'h0500;

  // register reached by one access
  typedef enum logic [4:0] {
    TGT_RX_TX,
    TGT_INT_EN,
    TGT_INT_ID_FC,
    TGT_LINE_CTRL,
    TGT_MODEM_CTRL,
    TGT_LINE_STAT,
    TGT_MODEM_STAT,
    TGT_SCRATCH,
    TGT_DIV_LOW,
    TGT_DIV_HIGH,
    TGT_ENH_FEAT,
    TGT_FLOW_ON1,
    TGT_FLOW_ON2,
    TGT_FLOW_OFF1,
    TGT_FLOW_OFF2,
    TGT_TX_CTRL,
    TGT_TRIG_LVL,
    TGT_FIFO_RDY,
    TGT_NONE
  } target_t;

endpackage

//--- core/uart_baud_gen.sv
// baud generator: optional divide-by-4 then 16-bit divisor
`timescale 1ns/1ps
module uart_baud_gen (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [15:0] divisor,
  input  wire logic        prescaleBy4,
  output logic             baudTick16
);

  logic [1:0]  preCnt_ff;
  logic [1:0]  nxt_preCnt;
  logic [15:0] divCnt_ff;
  logic [15:0] nxt_divCnt;
  logic        tick_ff;
  logic        nxt_tick;
  logic        preEn;

  assign baudTick16 = tick_ff;

  // prescale enable, then divide; zero divisor parks the counter
  always_comb begin
    nxt_divCnt = divCnt_ff;
    nxt_tick   = 1'b0;
    if (prescaleBy4) begin
      nxt_preCnt = preCnt_ff + 2'h1;
      preEn      = (preCnt_ff == uart_regsel_pkg::PRESCALE_LAST);
    end else begin
      nxt_preCnt = uart_regsel_pkg::RESET_PRE;
      preEn      = 1'b1;
    end
    if (divisor == 16'h0000) begin
      nxt_divCnt = 16'h0000; // [RQ16]
    end else if (preEn) begin
      // >= so a divisor lowered mid-count wraps at once
      if (divCnt_ff >= divisor - 16'h0001) begin
        nxt_divCnt = 16'h0000;
        nxt_tick   = 1'b1; // [RQ17]
      end else begin
        nxt_divCnt = divCnt_ff + 16'h0001;
      end
    end
  end

  // counter registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      preCnt_ff <= uart_regsel_pkg::RESET_PRE;
      divCnt_ff <= uart_regsel_pkg::RESET_DIV;
      tick_ff   <= 1'b0;
    end else begin
      preCnt_ff <= nxt_preCnt;
      divCnt_ff <= nxt_divCnt;
      tick_ff   <= nxt_tick;
    end
  end

endmodule

//--- core/uart_register_select.sv
// register select and control registers for one uart channel (channel a)
// Function
// RQ1: address plus qualifier bits choose the register
// RQ2: addr 0 reads receive, writes transmit holding
// RQ3: addr 1 interrupt enables read and write
// RQ4: addr 2 reads interrupt ident, writes fifo control
// RQ5: line and modem control read/write at 3, 4
// RQ6: line/modem status read-only, writes ignored
// RQ7: addr 7 scratch byte read/write
// RQ8: some registers only reachable via qualifier bits
// RQ9: divisor access bit maps 0,1 to divisor
// RQ10: line control BFh opens enhanced and flow chars
// RQ11: enhanced bit and modem bit 6 open 6,7
// RQ12: fifo ready read at 7 when enabled
// RQ13: prescaler bit writable only with enhanced bit
// RQ14: host divisors for 1.8432 MHz reference
// RQ15: host divisors for 3.072 MHz reference
// RQ16: divisor is high:low; zero stops baud ticks
// RQ17: divide reference, optional by four, to 16x
// RQ18: qualified selections win in fixed priority order
`timescale 1ns/1ps
module uart_register_select (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       channel_a_select_n,
  input  wire logic       channel_b_select_n,
  input  wire logic       reg_sel_bit0,
  input  wire logic       reg_sel_bit1,
  input  wire logic       reg_sel_bit2,
  input  wire logic       ioRead_n,
  input  wire logic       ioWrite_n,
  input  wire logic [7:0] busDataIn,
  output logic      [7:0] busDataOut,
  output logic            busDataOe_n,
  input  wire logic [7:0] rxData,
  input  wire logic [7:0] intIdent,
  input  wire logic [7:0] lineStatus,
  input  wire logic [7:0] modemStatus,
  input  wire logic [3:0] fifoReady,
  output logic            rxPop,
  output logic            intIdentRead,
  output logic            lineStatusRead,
  output logic            modemStatusRead,
  output logic            txLoad,
  output logic            fifoCtrlWrite,
  output logic      [7:0] writeData,
  output logic      [7:0] interruptEnables,
  output logic      [7:0] lineControl,
  output logic      [7:0] modemControl,
  output logic      [7:0] enhancedFeatures,
  output logic      [7:0] flowOnCharOne,
  output logic      [7:0] flowOnCharTwo,
  output logic      [7:0] flowOffCharOne,
  output logic      [7:0] flowOffCharTwo,
  output logic      [7:0] transmissionControl,
  output logic      [7:0] triggerLevel,
  output logic            baudTick16
);

  // register choice from address, direction and qualifiers
  function automatic uart_regsel_pkg::target_t decodeTarget(
    input logic [2:0] addr,
    input logic       isWrite,
    input logic [7:0] lc, ef, mc
  );
    uart_regsel_pkg::target_t tgt;
    logic divOn, enhOn, tcOn, rdyOn;
    divOn = lc[uart_regsel_pkg::LC_DIV_ACCESS_BIT];
    enhOn = (lc == uart_regsel_pkg::LC_ENH_KEY);
    tcOn  = ef[uart_regsel_pkg::EF_ENH_FUNC_BIT] &
            mc[uart_regsel_pkg::MC_TC_TL_EN_BIT];
    rdyOn = !isWrite & mc[uart_regsel_pkg::MC_FIFO_RDY_EN_BIT] &
            !mc[uart_regsel_pkg::MC_LOOPBACK_BIT];
    // normal set first, then overridden by priority below
    unique case (addr)
      uart_regsel_pkg::ADDR_RX_TX:      tgt = uart_regsel_pkg::TGT_RX_TX;
      uart_regsel_pkg::ADDR_INT_EN:     tgt = uart_regsel_pkg::TGT_INT_EN;
      uart_regsel_pkg::ADDR_INT_ID:     tgt = uart_regsel_pkg::TGT_INT_ID_FC;
      uart_regsel_pkg::ADDR_LINE_CTRL:  tgt = uart_regsel_pkg::TGT_LINE_CTRL;
      uart_regsel_pkg::ADDR_MODEM_CTRL: tgt = uart_regsel_pkg::TGT_MODEM_CTRL;
      uart_regsel_pkg::ADDR_LINE_STAT:  tgt = uart_regsel_pkg::TGT_LINE_STAT;
      uart_regsel_pkg::ADDR_MODEM_STAT: tgt = uart_regsel_pkg::TGT_MODEM_STAT;
      uart_regsel_pkg::ADDR_SCRATCH:    tgt = uart_regsel_pkg::TGT_SCRATCH;
    endcase
    if (isWrite && (tgt == uart_regsel_pkg::TGT_LINE_STAT ||
                    tgt == uart_regsel_pkg::TGT_MODEM_STAT)) begin
      tgt = uart_regsel_pkg::TGT_NONE; // [RQ6]
    end
    // lowest qualified priority applied first, highest last
    if (rdyOn && addr == uart_regsel_pkg::ADDR_SCRATCH) begin
      tgt = uart_regsel_pkg::TGT_FIFO_RDY; // [RQ12] [RQ18]
    end
    if (tcOn && addr[2:1] == uart_regsel_pkg::ADDR_MODEM_STAT[2:1]) begin
      tgt = addr[0] ? uart_regsel_pkg::TGT_TRIG_LVL
                    : uart_regsel_pkg::TGT_TX_CTRL; // [RQ11] [RQ8] [RQ18]
    end
    if (enhOn && addr == uart_regsel_pkg::ADDR_INT_ID) begin
      tgt = uart_regsel_pkg::TGT_ENH_FEAT; // [RQ10] [RQ8]
    end
    if (enhOn && addr >= uart_regsel_pkg::ADDR_MODEM_CTRL) begin
      unique case (addr[1:0])
        2'h0: tgt = uart_regsel_pkg::TGT_FLOW_ON1; // [RQ10]
        2'h1: tgt = uart_regsel_pkg::TGT_FLOW_ON2; // [RQ10]
        2'h2: tgt = uart_regsel_pkg::TGT_FLOW_OFF1; // [RQ10]
        2'h3: tgt = uart_regsel_pkg::TGT_FLOW_OFF2; // [RQ18]
      endcase
    end
    if (divOn && addr[2:1] == uart_regsel_pkg::ADDR_RX_TX[2:1]) begin
      tgt = addr[0] ? uart_regsel_pkg::TGT_DIV_HIGH
                    : uart_regsel_pkg::TGT_DIV_LOW; // [RQ9] [RQ18]
    end
    return tgt;
  endfunction

  logic [2:0] addr;
  logic       ownSel, anySel;
  logic       readStart, writeStart, readOk;
  logic [7:0] readByte;
  uart_regsel_pkg::target_t rdTgt, wrTgt;
  // bus interface state
  logic       prevRead_ff, nxt_prevRead;
  logic       prevWrite_ff, nxt_prevWrite;
  logic [7:0] dataOut_ff, nxt_dataOut;
  logic       oe_n_ff, nxt_oe_n;
  logic       rxPop_ff, nxt_rxPop;
  logic       identRd_ff, nxt_identRd;
  logic       lineRd_ff, nxt_lineRd;
  logic       modemRd_ff, nxt_modemRd;
  logic       txLoad_ff, nxt_txLoad;
  logic       fcWrite_ff, nxt_fcWrite;
  logic [7:0] wrData_ff, nxt_wrData;
  // control registers
  logic [7:0] intEn_ff,   nxt_intEn;
  logic [7:0] lineCtl_ff, nxt_lineCtl;
  logic [7:0] modemCtl_ff, nxt_modemCtl;
  logic [7:0] scratch_ff, nxt_scratch;
  logic [7:0] divLow_ff,  nxt_divLow;
  logic [7:0] divHigh_ff, nxt_divHigh;
  logic [7:0] enhFeat_ff, nxt_enhFeat;
  logic [7:0] flowOn1_ff, nxt_flowOn1;
  logic [7:0] flowOn2_ff, nxt_flowOn2;
  logic [7:0] flowOff1_ff, nxt_flowOff1;
  logic [7:0] flowOff2_ff, nxt_flowOff2;
  logic [7:0] txCtl_ff,   nxt_txCtl;
  logic [7:0] trigLvl_ff, nxt_trigLvl;

  // access qualification; strobes act on their first low cycle
  assign addr       = {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
  assign ownSel     = !channel_a_select_n;
  assign anySel     = ownSel | !channel_b_select_n;
  assign rdTgt      = decodeTarget(addr, 1'b0, lineCtl_ff, enhFeat_ff,
                                   modemCtl_ff); // [RQ1]
  assign wrTgt      = decodeTarget(addr, 1'b1, lineCtl_ff, enhFeat_ff,
                                   modemCtl_ff); // [RQ1]
  // fifo ready answers to either channel's select
  assign readOk     = !ioRead_n & (ownSel |
                      (anySel & rdTgt == uart_regsel_pkg::TGT_FIFO_RDY));
  assign readStart  = readOk & prevRead_ff;
  assign writeStart = !ioWrite_n & prevWrite_ff & ownSel;

  // read data mux
  always_comb begin
    unique case (rdTgt)
      uart_regsel_pkg::TGT_RX_TX:      readByte = rxData; // [RQ2]
      uart_regsel_pkg::TGT_INT_EN:     readByte = intEn_ff; // [RQ3]
      uart_regsel_pkg::TGT_INT_ID_FC:  readByte = intIdent; // [RQ4]
      uart_regsel_pkg::TGT_LINE_CTRL:  readByte = lineCtl_ff; // [RQ5]
      uart_regsel_pkg::TGT_MODEM_CTRL: readByte = modemCtl_ff; // [RQ5]
      uart_regsel_pkg::TGT_LINE_STAT:  readByte = lineStatus; // [RQ6]
      uart_regsel_pkg::TGT_MODEM_STAT: readByte = modemStatus; // [RQ6]
      uart_regsel_pkg::TGT_SCRATCH:    readByte = scratch_ff; // [RQ7]
      uart_regsel_pkg::TGT_DIV_LOW:    readByte = divLow_ff; // [RQ9]
      uart_regsel_pkg::TGT_DIV_HIGH:   readByte = divHigh_ff; // [RQ9]
      uart_regsel_pkg::TGT_ENH_FEAT:   readByte = enhFeat_ff;
      uart_regsel_pkg::TGT_FLOW_ON1:   readByte = flowOn1_ff;
      uart_regsel_pkg::TGT_FLOW_ON2:   readByte = flowOn2_ff;
      uart_regsel_pkg::TGT_FLOW_OFF1:  readByte = flowOff1_ff;
      uart_regsel_pkg::TGT_FLOW_OFF2:  readByte = flowOff2_ff;
      uart_regsel_pkg::TGT_TX_CTRL:    readByte = txCtl_ff;
      uart_regsel_pkg::TGT_TRIG_LVL:   readByte = trigLvl_ff;
      uart_regsel_pkg::TGT_FIFO_RDY: begin
        readByte = {2'h0, fifoReady[3:2], 2'h0, fifoReady[1:0]}; // [RQ12]
      end
      default:                         readByte = 8'h00;
    endcase
  end

  // bus side next state: data driven while read strobe stays low
  always_comb begin
    nxt_prevRead  = ioRead_n;
    nxt_prevWrite = ioWrite_n;
    nxt_dataOut   = readOk ? readByte : dataOut_ff;
    nxt_oe_n      = !readOk;
    nxt_rxPop     = readStart & (rdTgt == uart_regsel_pkg::TGT_RX_TX);
    nxt_identRd   = readStart & (rdTgt == uart_regsel_pkg::TGT_INT_ID_FC);
    nxt_lineRd    = readStart & (rdTgt == uart_regsel_pkg::TGT_LINE_STAT);
    nxt_modemRd   = readStart & (rdTgt == uart_regsel_pkg::TGT_MODEM_STAT);
    nxt_txLoad = writeStart & (wrTgt == uart_regsel_pkg::TGT_RX_TX); // [RQ2]
    nxt_fcWrite   = writeStart &
                    (wrTgt == uart_regsel_pkg::TGT_INT_ID_FC); // [RQ4]
    nxt_wrData    = writeStart ? busDataIn : wrData_ff;
  end

  // bus side registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prevRead_ff  <= 1'b1;
      prevWrite_ff <= 1'b1;
      dataOut_ff   <= uart_regsel_pkg::RESET_BYTE;
      oe_n_ff      <= 1'b1;
      rxPop_ff     <= 1'b0;
      identRd_ff   <= 1'b0;
      lineRd_ff    <= 1'b0;
      modemRd_ff   <= 1'b0;
      txLoad_ff    <= 1'b0;
      fcWrite_ff   <= 1'b0;
      wrData_ff    <= uart_regsel_pkg::RESET_BYTE;
    end else begin
      prevRead_ff  <= nxt_prevRead;
      prevWrite_ff <= nxt_prevWrite;
      dataOut_ff   <= nxt_dataOut;
      oe_n_ff      <= nxt_oe_n;
      rxPop_ff     <= nxt_rxPop;
      identRd_ff   <= nxt_identRd;
      lineRd_ff    <= nxt_lineRd;
      modemRd_ff   <= nxt_modemRd;
      txLoad_ff    <= nxt_txLoad;
      fcWrite_ff   <= nxt_fcWrite;
      wrData_ff    <= nxt_wrData;
    end
  end

  // register writes; status locations fall to TGT_NONE and are dropped
  always_comb begin
    nxt_intEn    = intEn_ff;
    nxt_lineCtl  = lineCtl_ff;
    nxt_modemCtl = modemCtl_ff;
    nxt_scratch  = scratch_ff;
    nxt_divLow   = divLow_ff;
    nxt_divHigh  = divHigh_ff;
    nxt_enhFeat  = enhFeat_ff;
    nxt_flowOn1  = flowOn1_ff;
    nxt_flowOn2  = flowOn2_ff;
    nxt_flowOff1 = flowOff1_ff;
    nxt_flowOff2 = flowOff2_ff;
    nxt_txCtl    = txCtl_ff;
    nxt_trigLvl  = trigLvl_ff;
    if (writeStart) begin
      unique case (wrTgt)
        uart_regsel_pkg::TGT_INT_EN:    nxt_intEn = busDataIn; // [RQ3]
        uart_regsel_pkg::TGT_LINE_CTRL: nxt_lineCtl = busDataIn; // [RQ5]
        uart_regsel_pkg::TGT_MODEM_CTRL: begin
          nxt_modemCtl = busDataIn; // [RQ5]
          // prescaler select held unless enhanced functions are on
          if (!enhFeat_ff[uart_regsel_pkg::EF_ENH_FUNC_BIT]) begin
            nxt_modemCtl[uart_regsel_pkg::MC_PRESCALE_BIT] =
              modemCtl_ff[uart_regsel_pkg::MC_PRESCALE_BIT]; // [RQ13]
          end
        end
        uart_regsel_pkg::TGT_SCRATCH:   nxt_scratch = busDataIn; // [RQ7]
        uart_regsel_pkg::TGT_DIV_LOW:   nxt_divLow = busDataIn; // [RQ9]
        uart_regsel_pkg::TGT_DIV_HIGH:  nxt_divHigh = busDataIn; // [RQ9]
        uart_regsel_pkg::TGT_ENH_FEAT:  nxt_enhFeat = busDataIn; // [RQ10]
        uart_regsel_pkg::TGT_FLOW_ON1:  nxt_flowOn1 = busDataIn;
        uart_regsel_pkg::TGT_FLOW_ON2:  nxt_flowOn2 = busDataIn;
        uart_regsel_pkg::TGT_FLOW_OFF1: nxt_flowOff1 = busDataIn;
        uart_regsel_pkg::TGT_FLOW_OFF2: nxt_flowOff2 = busDataIn;
        uart_regsel_pkg::TGT_TX_CTRL:   nxt_txCtl = busDataIn; // [RQ11]
        uart_regsel_pkg::TGT_TRIG_LVL:  nxt_trigLvl = busDataIn; // [RQ11]
        default: ; // pulses only, or a dropped write
      endcase
    end
  end

  // control registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      intEn_ff    <= uart_regsel_pkg::RESET_BYTE;
      lineCtl_ff  <= uart_regsel_pkg::RESET_BYTE;
      modemCtl_ff <= uart_regsel_pkg::RESET_BYTE;
      scratch_ff  <= uart_regsel_pkg::RESET_BYTE;
      divLow_ff   <= uart_regsel_pkg::RESET_BYTE;
      divHigh_ff  <= uart_regsel_pkg::RESET_BYTE;
      enhFeat_ff  <= uart_regsel_pkg::RESET_BYTE;
      flowOn1_ff  <= uart_regsel_pkg::RESET_BYTE;
      flowOn2_ff  <= uart_regsel_pkg::RESET_BYTE;
      flowOff1_ff <= uart_regsel_pkg::RESET_BYTE;
      flowOff2_ff <= uart_regsel_pkg::RESET_BYTE;
      txCtl_ff    <= uart_regsel_pkg::RESET_BYTE;
      trigLvl_ff  <= uart_regsel_pkg::RESET_BYTE;
    end else begin
      intEn_ff    <= nxt_intEn;
      lineCtl_ff  <= nxt_lineCtl;
      modemCtl_ff <= nxt_modemCtl;
      scratch_ff  <= nxt_scratch;
      divLow_ff   <= nxt_divLow;
      divHigh_ff  <= nxt_divHigh;
      enhFeat_ff  <= nxt_enhFeat;
      flowOn1_ff  <= nxt_flowOn1;
      flowOn2_ff  <= nxt_flowOn2;
      flowOff1_ff <= nxt_flowOff1;
      flowOff2_ff <= nxt_flowOff2;
      txCtl_ff    <= nxt_txCtl;
      trigLvl_ff  <= nxt_trigLvl;
    end
  end

  // baud tick from the 16-bit divisor, low byte least significant
  uart_baud_gen u_baud (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .divisor     ({divHigh_ff, divLow_ff}), // [RQ16]
    .prescaleBy4 (modemCtl_ff[uart_regsel_pkg::MC_PRESCALE_BIT]), // [RQ17]
    .baudTick16  (baudTick16)
  );

  // outputs straight from registers
  assign busDataOut          = dataOut_ff;
  assign busDataOe_n         = oe_n_ff;
  assign rxPop               = rxPop_ff;
  assign intIdentRead        = identRd_ff;
  assign lineStatusRead      = lineRd_ff;
  assign modemStatusRead     = modemRd_ff;
  assign txLoad              = txLoad_ff;
  assign fifoCtrlWrite       = fcWrite_ff;
  assign writeData           = wrData_ff;
  assign interruptEnables    = intEn_ff;
  assign lineControl         = lineCtl_ff;
  assign modemControl        = modemCtl_ff;
  assign enhancedFeatures    = enhFeat_ff;
  assign flowOnCharOne       = flowOn1_ff;
  assign flowOnCharTwo       = flowOn2_ff;
  assign flowOffCharOne      = flowOff1_ff;
  assign flowOffCharTwo      = flowOff2_ff;
  assign transmissionControl = txCtl_ff;
  assign triggerLevel        = trigLvl_ff;

endmodule

//--- sim/uart_host_model.sv
// host processor model on the 8-bit register bus
`timescale 1ns/1ps
module uart_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] busDataOut,
  output logic            channel_a_select_n,
  output logic            channel_b_select_n,
  output logic      [2:0] regAddr,
  output logic            ioRead_n,
  output logic            ioWrite_n,
  output logic      [7:0] busDataIn
);
  // idle bus: strobes and selects high, data zero
  initial begin
    channel_a_select_n = 1'h1;
    channel_b_select_n = 1'h1;
    regAddr = 3'h0;
    ioRead_n = 1'h1;
    ioWrite_n = 1'h1;
    busDataIn = 8'h00;
  end

  // write: held over one taking edge, then one high cycle of gap
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    busDataIn = d;
    channel_a_select_n = 1'h0;
    ioWrite_n = 1'h0;
    @(negedge sys_clk);
    ioWrite_n = 1'h1;
    channel_a_select_n = 1'h1;
    busDataIn = ~d; // released data must not look valid
  endtask

  // read: answer taken half a cycle after the taking edge
  task automatic rd(input logic [2:0] a, input logic useB,
                    output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    channel_a_select_n = useB;
    channel_b_select_n = !useB;
    ioRead_n = 1'h0;
    @(negedge sys_clk);
    d = busDataOut;
    ioRead_n = 1'h1;
    channel_a_select_n = 1'h1;
    channel_b_select_n = 1'h1;
  endtask
endmodule

//--- sim/uart_register_select_chk.sv
// port-level checker for the uart register select block
`timescale 1ns/1ps
module uart_register_select_chk (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       channel_a_select_n,
  input wire logic       channel_b_select_n,
  input wire logic       reg_sel_bit0,
  input wire logic       reg_sel_bit1,
  input wire logic       reg_sel_bit2,
  input wire logic       ioRead_n,
  input wire logic       ioWrite_n,
  input wire logic [7:0] busDataIn,
  input wire logic [7:0] busDataOut,
  input wire logic       busDataOe_n,
  input wire logic [7:0] rxData,
  input wire logic [3:0] fifoReady,
  input wire logic       rxPop,
  input wire logic       txLoad,
  input wire logic       fifoCtrlWrite,
  input wire logic [7:0] writeData,
  input wire logic [7:0] interruptEnables,
  input wire logic [7:0] lineControl,
  input wire logic [7:0] modemControl,
  input wire logic [7:0] enhancedFeatures,
  input wire logic       baudTick16
);
  logic       rdPrev_ff;
  logic       wrPrev_ff;
  logic [2:0] addr;
  logic       rdStart;
  logic       wrTake;
  logic       normSet;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // strobe history; a held-low write must count once only
  always_ff @(posedge sys_clk) begin
    rdPrev_ff <= srst | ioRead_n;
    wrPrev_ff <= srst | ioWrite_n;
  end
  assign addr = {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
  assign rdStart = !ioRead_n && rdPrev_ff && !channel_a_select_n;
  assign wrTake = !ioWrite_n && wrPrev_ff && !channel_a_select_n;
  assign normSet = lineControl != 8'hBF;

  a_tx_load: assert property (wrTake && addr == 3'h0
    && !lineControl[7] |=> txLoad && writeData == $past(busDataIn))
    else $error("tx load");
  a_rx_pop: assert property (rdStart && addr == 3'h0
    && !lineControl[7] |=> rxPop && !busDataOe_n
    && busDataOut == $past(rxData)) else $error("rx read");
  a_ie_write: assert property (wrTake && addr == 3'h1
    && !lineControl[7] |=> interruptEnables == $past(busDataIn))
    else $error("ie write");
  a_fc_write: assert property (wrTake && addr == 3'h2 && normSet
    |=> fifoCtrlWrite && writeData == $past(busDataIn)) else $error("fc");
  a_efr_gate: assert property (wrTake && addr == 3'h2 && !normSet
    |=> enhancedFeatures == $past(busDataIn) && !fifoCtrlWrite)
    else $error("ef write");
  a_prescale_lock: assert property (wrTake && addr == 3'h4 && normSet
    && !enhancedFeatures[4] |=> modemControl == {$past(modemControl[7]),
    $past(busDataIn[6:0])}) else $error("prescale bit");
  a_fifo_rdy: assert property (!ioRead_n && addr == 3'h7 && normSet
    && modemControl[2] && !modemControl[4]
    && !(enhancedFeatures[4] && modemControl[6])
    && !(channel_a_select_n && channel_b_select_n)
    |=> busDataOut == {2'h0, $past(fifoReady[3:2]), 2'h0,
    $past(fifoReady[1:0])}) else $error("fifo ready");
  a_oe_release: assert property ($rose(ioRead_n) |=> busDataOe_n)
    else $error("bus not released");
  a_pulse_once: assert property (rxPop |=> !rxPop)
    else $error("pop pulse long");

  // main scenarios reached
  c_tx: cover property (txLoad);
  c_pop: cover property (rxPop);
  c_tick: cover property (baudTick16);
endmodule

bind uart_register_select uart_register_select_chk chk (
  .sys_clk(sys_clk), .srst(srst), .channel_a_select_n(channel_a_select_n),
  .channel_b_select_n(channel_b_select_n), .reg_sel_bit0(reg_sel_bit0),
  .reg_sel_bit1(reg_sel_bit1), .reg_sel_bit2(reg_sel_bit2),
  .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .busDataIn(busDataIn),
  .busDataOut(busDataOut), .busDataOe_n(busDataOe_n), .rxData(rxData),
  .fifoReady(fifoReady), .rxPop(rxPop), .txLoad(txLoad),
  .fifoCtrlWrite(fifoCtrlWrite), .writeData(writeData),
  .interruptEnables(interruptEnables), .lineControl(lineControl),
  .modemControl(modemControl), .enhancedFeatures(enhancedFeatures),
  .baudTick16(baudTick16));

//--- sim/tb.sv
// self-checking bench for the uart register select block
`timescale 1ns/1ps
module tb;
  logic       sys_clk;
  logic       srst;
  logic       channel_a_select_n;
  logic       channel_b_select_n;
  logic [2:0] regAddr;
  logic       ioRead_n;
  logic       ioWrite_n;
  logic [7:0] busDataIn;
  logic [7:0] busDataOut;
  logic [7:0] d;
  int         n_fail;
  int         checks;

  uart_host_model host (.sys_clk(sys_clk), .busDataOut(busDataOut),
    .channel_a_select_n(channel_a_select_n),
    .channel_b_select_n(channel_b_select_n), .regAddr(regAddr),
    .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .busDataIn(busDataIn));

  // status inputs fixed; outputs read through the instance
  uart_register_select uut (.sys_clk(sys_clk), .srst(srst),
    .channel_a_select_n(channel_a_select_n),
    .channel_b_select_n(channel_b_select_n), .reg_sel_bit0(regAddr[0]),
    .reg_sel_bit1(regAddr[1]), .reg_sel_bit2(regAddr[2]),
    .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .busDataIn(busDataIn),
    .busDataOut(busDataOut), .busDataOe_n(), .rxData(8'h71),
    .intIdent(8'hC1), .lineStatus(8'h60), .modemStatus(8'hB0),
    .fifoReady(4'h9), .rxPop(), .intIdentRead(), .lineStatusRead(),
    .modemStatusRead(), .txLoad(), .fifoCtrlWrite(), .writeData(),
    .interruptEnables(), .lineControl(), .modemControl(),
    .enhancedFeatures(), .flowOnCharOne(), .flowOnCharTwo(),
    .flowOffCharOne(), .flowOffCharTwo(), .transmissionControl(),
    .triggerLevel(), .baudTick16());

  always #2 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // spacing of two ticks; bounded so a dead generator ends the run
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    while (uut.baudTick16 !== 1'h1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (uut.baudTick16 !== 1'h1 && n < 300);
    if (n >= 300) begin
      n_fail++;
      end_sim();
    end
    chk(8'(n), 8'(exp), "tick gap");
  endtask

  task automatic t_normal();
    host.wr(3'h1, 8'h5A);
    host.rd(3'h1, 1'h0, d);
    chk(d, 8'h5A, "ie");
    host.wr(3'h3, 8'h1B);
    host.rd(3'h3, 1'h0, d);
    chk(d, 8'h1B, "lc");
    host.wr(3'h4, 8'h83);
    host.rd(3'h4, 1'h0, d);
    chk(d, 8'h03, "mc locked bit");
    host.wr(3'h7, 8'hA5);
    host.rd(3'h7, 1'h0, d);
    chk(d, 8'hA5, "scratch");
    host.wr(3'h0, 8'h3C);
    chk({7'h0, uut.txLoad}, 8'h01, "tx load");
    host.rd(3'h0, 1'h0, d);
    chk({d[7:1], uut.rxPop}, 8'h71, "rx read");
    host.rd(3'h2, 1'h0, d);
    chk({d[7:1], uut.intIdentRead}, 8'hC1, "ident");
    host.wr(3'h2, 8'h07);
    chk({uut.writeData[7:1], uut.fifoCtrlWrite}, 8'h07, "fc");
    host.wr(3'h5, 8'hFF);
    host.wr(3'h6, 8'hFF);
    host.rd(3'h5, 1'h0, d);
    chk({d[7:1], uut.lineStatusRead}, 8'h61, "ls");
    host.rd(3'h6, 1'h0, d);
    chk({d[7:1], uut.modemStatusRead}, 8'hB1, "ms");
    chk(uut.lineControl, 8'h1B, "status write");
    $display("t_normal done");
  endtask

  task automatic t_divisor();
    host.wr(3'h3, 8'h80);
    host.wr(3'h0, uart_regsel_pkg::DIV_3M072_38400[7:0]);
    chk({7'h0, uut.txLoad}, 8'h00, "no tx load");
    host.wr(3'h1, uart_regsel_pkg::DIV_3M072_38400[15:8]);
    chk(uut.interruptEnables, 8'h5A, "ie kept");
    host.rd(3'h0, 1'h0, d);
    chk(d, 8'h05, "div low");
    tick_gap(5);
    host.wr(3'h0, uart_regsel_pkg::DIV_1M8432_9600[7:0]);
    tick_gap(12);
    $display("t_divisor done");
  endtask

  task automatic t_enhanced();
    host.wr(3'h3, 8'hBF);
    host.wr(3'h2, 8'h10);
    chk({uut.fifoCtrlWrite, uut.enhancedFeatures[6:0]}, 8'h10, "ef");
    for (int a = 4; a < 8; a++) begin
      host.wr(3'(a), 8'hC0 + 8'(a));
    end
    chk(uut.flowOnCharOne, 8'hC4, "on1");
    chk(uut.flowOnCharTwo, 8'hC5, "on2");
    chk(uut.flowOffCharOne, 8'hC6, "off1");
    host.rd(3'h7, 1'h0, d);
    chk(d, 8'hC7, "off2");
    chk(uut.modemControl, 8'h03, "mc kept");
    host.rd(3'h0, 1'h0, d);
    chk(d, 8'h0C, "div over enh");
    host.wr(3'h3, 8'h03);
    host.wr(3'h4, 8'hC4);
    chk(uut.modemControl, 8'hC4, "mc prescale");
    host.wr(3'h6, 8'h11);
    host.wr(3'h7, 8'h22);
    chk(uut.transmissionControl, 8'h11, "tc");
    host.rd(3'h7, 1'h0, d);
    chk(d, 8'h22, "tl over ready");
    tick_gap(48);
    $display("t_enhanced done");
  endtask

  task automatic t_fifo_ready();
    host.wr(3'h4, 8'h84);
    host.rd(3'h7, 1'h1, d);
    chk(d, 8'h21, "ready via b");
    host.rd(3'h7, 1'h0, d);
    chk(d, 8'h21, "ready via a");
    host.wr(3'h4, 8'h94);
    host.rd(3'h7, 1'h0, d);
    chk(d, 8'hA5, "loopback scratch");
    $display("t_fifo_ready done");
  endtask

  initial begin
    sys_clk = 1'h0;
    srst = 1'h1;
    n_fail = 0;
    checks = 0;
    repeat (4) @(negedge sys_clk);
    srst = 1'h0;
    t_normal();
    t_divisor();
    t_enhanced();
    t_fifo_ready();
    end_sim();
  end
endmodule
